// ===== rtl/bdsc_map.vh
// constants for the dma start/completion controller: own register map,
// device register offsets and bit positions, timing counts.
// assumes a 10 MHz clk and the device register offsets chosen here.
`ifndef BDSC_MAP_VH
`define BDSC_MAP_VH

// ----------------------------------------
// own registers, word index on sw_addr
// ----------------------------------------
`define BDSC_R_CTRL 4'h0
`define BDSC_R_HADDR 4'h1
`define BDSC_R_RADDR 4'h2
`define BDSC_R_LEN 4'h3
`define BDSC_R_AMOD 4'h4
`define BDSC_R_STAT 4'h5
`define BDSC_R_DCMD 4'h6

// ctrl fields
`define BDSC_C_GO 0
`define BDSC_C_TOVME 1
`define BDSC_C_LONG 2
`define BDSC_C_DPRAM 3
`define BDSC_C_IRQ 4
`define BDSC_C_BLOCK 5
`define BDSC_C_PAUSE 6
// status fields
`define BDSC_S_BUSY 0
`define BDSC_S_DONE 1
`define BDSC_S_ERR 2
`define BDSC_S_ELO 8
`define BDSC_S_EHI 15

// ----------------------------------------
// device register offsets
// ----------------------------------------
`define BDSC_D_CMD 8'h00
`define BDSC_D_LA0 8'h01
`define BDSC_D_LA1 8'h02
`define BDSC_D_LA2 8'h03
`define BDSC_D_RA0 8'h04
`define BDSC_D_RA1 8'h05
`define BDSC_D_RA2 8'h06
`define BDSC_D_RA3 8'h07
`define BDSC_D_LREM 8'h08
`define BDSC_D_RREM 8'h09
`define BDSC_D_PK0 8'h0A
`define BDSC_D_PK1 8'h0B
`define BDSC_D_IRQC 8'h0C
`define BDSC_D_RC2 8'h0D
`define BDSC_D_AMOD 8'h0E
`define BDSC_D_STAT 8'h0F

// device command register bits
`define BDSC_K_INPROG 0
`define BDSC_K_DONE 1
`define BDSC_K_IRQEN 2
`define BDSC_K_LONG 4
`define BDSC_K_TOVME 5
`define BDSC_K_DPRAM 6
`define BDSC_K_START 7
// device interrupt control bits
`define BDSC_I_NORMEN 6
// remote control two bits
`define BDSC_X_NOIRQ 4
`define BDSC_X_BLOCK 5
`define BDSC_X_PAUSE 7
// error bits of the device status register
`define BDSC_ERR_MASK 8'hC7

// ----------------------------------------
// timing
// ----------------------------------------
`define BDSC_CLK_MHZ 10
`define BDSC_POLL_GAP_US 10
`define BDSC_POLL_GAP_CYC (`BDSC_POLL_GAP_US * `BDSC_CLK_MHZ)

`endif

// ===== rtl/bdsc_sync.v
// two-flop synchroniser for the device interrupt pin.
// assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module bdsc_sync (
  input wire clk, // system clock
  input wire srst, // synchronous reset, high
  input wire din, // asynchronous level
  output wire dout // synchronised level
);
  reg s1_reg;
  reg s2_reg;

  always @(posedge clk) begin
    if (srst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
    end
  end

  assign dout = s2_reg;
endmodule
`default_nettype wire

// ===== rtl/bdsc_gap.v
// down counter that spaces the completion polls apart.
// assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "bdsc_map.vh"
module bdsc_gap (
  input wire clk, // system clock
  input wire srst, // synchronous reset, high
  input wire load, // restart the gap
  output wire expired // gap has run out
);
  localparam integer GAP_CYC = `BDSC_POLL_GAP_CYC;
  localparam [7:0] GAP = GAP_CYC[7:0];
  reg [7:0] cnt_reg;

  always @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 8'h00;
    end else if (load) begin
      cnt_reg <= GAP;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  assign expired = (cnt_reg == 8'h00);
endmodule
`default_nettype wire

// ===== rtl/bdsc_host.v
// host-side controller that programs, starts and completes one dma
// transfer on the adapter through its byte-wide register port.
// assumes a device port that takes a write in one strobe cycle and
// answers a read in the cycle after the strobe; software drives sw_*.
//
// Notes on behaviour
// RULE1: device raises done interrupt only with command and normal enables both set.
// RULE2: device shows interrupt-active while generating the done interrupt.
// RULE3: clearing the done flag acknowledges; device then withdraws the interrupt.
// RULE4: done flag and interrupt come on success and failure alike.
// RULE5: reading the command register shows done once the transfer ends.
// RULE6: command written first with options and start clear.
// RULE7: host address upper field picks mapping entry, low twelve bits offset.
// RULE8: device carries into the upper field at each 4K page.
// RULE9: remote address register loaded with the starting bus address.
// RULE10: both remainder counts get length modulo 256.
// RULE11: packet count is length divided by 256, plus remainder bytes.
// RULE12: interrupt-passing disable set in remote control before start.
// RULE13: remote control: block flag, pause flag, one flag always zero.
// RULE14: address modifier must match block mode and address width.
// RULE15: start by read-back of command, rewritten with start bit set.
// RULE16: command bits: direction, longword, target; start/done/busy/reserved clear.
// RULE17: in-progress bit shows a transfer; no other cable access meanwhile.
// RULE18: any listed status error bit set means the transfer failed.
// RULE19: writing zero to remote control resumes interrupt passing.
// RULE20: after status check clear command, then restore remote control.
// RULE21: do not poll the command register continuously.
// RULE22: mapping entries at a fixed offset, one longword apart.
// RULE23: entries give upper twenty address bits; invalid entry times out.
// RULE24: pause rearbitrates per 64 bytes, block per 256, non-block each.
// RULE25: in-progress set on start, cleared as done is set.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "bdsc_map.vh"
module bdsc_host (
  input wire clk, // system clock, 10 MHz
  input wire srst, // synchronous reset, high
  input wire [3:0] sw_addr, // own register index
  input wire [31:0] sw_wdata, // software write data
  input wire sw_wr, // software write strobe
  input wire sw_rd, // software read strobe
  output wire [31:0] sw_rdata, // read data, cycle after sw_rd
  output wire [7:0] dev_addr, // device register offset
  output wire [7:0] dev_wdata, // device write data
  output wire dev_wr, // device write strobe
  output wire dev_rd, // device read strobe
  input wire [7:0] dev_rdata, // device read data, cycle after dev_rd
  input wire dev_irq, // device interrupt pin, high
  output wire busy, // transfer sequence under way
  output wire done // sticky completion flag
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PROG = 4'h1;
  localparam [3:0] S_RD = 4'h2;
  localparam [3:0] S_RDW = 4'h3;
  localparam [3:0] S_CAP = 4'h4;
  localparam [3:0] S_START = 4'h5;
  localparam [3:0] S_WAIT = 4'h6;
  localparam [3:0] S_CHK = 4'h7;
  localparam [3:0] S_STAT = 4'h8;
  localparam [3:0] S_CLR = 4'h9;
  localparam [3:0] S_REST = 4'hA;
  localparam [3:0] LAST_STEP = 4'hE;

  reg [3:0] state_reg;
  reg [3:0] ret_reg;
  reg [3:0] step_reg;
  reg [7:0] cap_reg;
  reg [7:0] a_reg;
  reg [7:0] d_reg;
  reg wr_reg;
  reg rd_reg;
  reg [31:0] rdata_reg;

  // own registers
  reg [6:1] ctrl_reg;
  reg [23:0] haddr_reg;
  reg [31:0] raddr_reg;
  reg [23:0] len_reg;
  reg [7:0] amod_reg;
  reg done_reg;
  reg err_reg;
  reg [7:0] estat_reg;
  reg [7:0] dcmd_reg;

  wire irq_s;
  wire gap_out;
  wire gap_load;
  wire go;
  wire sw_clr_done;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  bdsc_sync u_sync (
    .clk(clk),
    .srst(srst),
    .din(dev_irq),
    .dout(irq_s)
  );

  // restart the gap on every poll so reads are spaced out
  assign gap_load = (state_reg == S_START) || (state_reg == S_CHK); // RULE21

  bdsc_gap u_gap (
    .clk(clk),
    .srst(srst),
    .load(gap_load),
    .expired(gap_out)
  );

  assign go = sw_wr && (sw_addr == `BDSC_R_CTRL) && sw_wdata[`BDSC_C_GO];
  assign sw_clr_done = sw_wr && (sw_addr == `BDSC_R_STAT) && sw_wdata[`BDSC_S_DONE];

  // ----------------------------------------
  // device command byte, options only
  // ----------------------------------------
  reg [7:0] opt_cmd;
  always @* begin
    opt_cmd = 8'h00; // RULE16
    opt_cmd[`BDSC_K_TOVME] = ctrl_reg[`BDSC_C_TOVME];
    opt_cmd[`BDSC_K_LONG] = ctrl_reg[`BDSC_C_LONG];
    opt_cmd[`BDSC_K_DPRAM] = ctrl_reg[`BDSC_C_DPRAM];
    opt_cmd[`BDSC_K_IRQEN] = ctrl_reg[`BDSC_C_IRQ]; // RULE1
  end

  reg [7:0] rc2_val;
  always @* begin
    rc2_val = 8'h00; // RULE13
    rc2_val[`BDSC_X_NOIRQ] = 1'b1; // RULE12
    rc2_val[`BDSC_X_BLOCK] = ctrl_reg[`BDSC_C_BLOCK] | ctrl_reg[`BDSC_C_PAUSE];
    rc2_val[`BDSC_X_PAUSE] = ctrl_reg[`BDSC_C_PAUSE];
  end

  // ----------------------------------------
  // programming table, one write per step
  // ----------------------------------------
  reg [7:0] t_addr;
  reg [7:0] t_data;
  always @* begin
    t_addr = `BDSC_D_CMD;
    t_data = opt_cmd; // RULE6
    case (step_reg)
      4'h1: begin
        t_addr = `BDSC_D_LA0;
        t_data = haddr_reg[7:0]; // RULE7
      end
      4'h2: begin
        t_addr = `BDSC_D_LA1;
        t_data = haddr_reg[15:8];
      end
      4'h3: begin
        t_addr = `BDSC_D_LA2;
        t_data = haddr_reg[23:16];
      end
      4'h4: begin
        t_addr = `BDSC_D_RA0;
        t_data = raddr_reg[7:0]; // RULE9
      end
      4'h5: begin
        t_addr = `BDSC_D_RA1;
        t_data = raddr_reg[15:8];
      end
      4'h6: begin
        t_addr = `BDSC_D_RA2;
        t_data = raddr_reg[23:16];
      end
      4'h7: begin
        t_addr = `BDSC_D_RA3;
        t_data = raddr_reg[31:24];
      end
      4'h8: begin
        t_addr = `BDSC_D_LREM;
        t_data = len_reg[7:0]; // RULE10
      end
      4'h9: begin
        t_addr = `BDSC_D_RREM;
        t_data = len_reg[7:0]; // RULE10
      end
      4'hA: begin
        t_addr = `BDSC_D_PK0;
        t_data = len_reg[15:8]; // RULE11
      end
      4'hB: begin
        t_addr = `BDSC_D_PK1;
        t_data = len_reg[23:16]; // RULE11
      end
      4'hC: begin
        t_addr = `BDSC_D_IRQC;
        t_data = {1'b0, ctrl_reg[`BDSC_C_IRQ], 6'h00}; // RULE1
      end
      4'hD: begin
        t_addr = `BDSC_D_RC2;
        t_data = rc2_val; // RULE12
      end
      4'hE: begin
        t_addr = `BDSC_D_AMOD;
        t_data = amod_reg; // RULE14
      end
      default: begin
        t_addr = `BDSC_D_CMD;
        t_data = opt_cmd;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= S_IDLE;
      ret_reg <= S_IDLE;
      step_reg <= 4'h0;
      cap_reg <= 8'h00;
      a_reg <= 8'h00;
      d_reg <= 8'h00;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          step_reg <= 4'h0;
          if (go) begin
            state_reg <= S_PROG;
          end
        end
        S_PROG: begin
          wr_reg <= 1'b1;
          a_reg <= t_addr;
          d_reg <= t_data;
          step_reg <= step_reg + 4'h1;
          if (step_reg == LAST_STEP) begin
            state_reg <= S_RD;
            ret_reg <= S_START;
          end
        end
        S_RD: begin
          rd_reg <= 1'b1;
          a_reg <= (ret_reg == S_STAT) ? `BDSC_D_STAT : `BDSC_D_CMD; // RULE15
          state_reg <= S_RDW;
        end
        S_RDW: begin
          state_reg <= S_CAP;
        end
        S_CAP: begin
          cap_reg <= dev_rdata;
          state_reg <= ret_reg;
        end
        S_START: begin
          // read-back value rewritten with start set
          wr_reg <= 1'b1;
          a_reg <= `BDSC_D_CMD;
          d_reg <= cap_reg | (8'h01 << `BDSC_K_START); // RULE15
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          // only the command register is touched until done
          a_reg <= `BDSC_D_CMD; // RULE17
          if (ctrl_reg[`BDSC_C_IRQ] ? irq_s : gap_out) begin
            state_reg <= S_RD;
            ret_reg <= S_CHK;
          end
        end
        S_CHK: begin
          if (cap_reg[`BDSC_K_DONE]) begin // RULE5
            a_reg <= `BDSC_D_STAT;
            state_reg <= S_RD;
            ret_reg <= S_STAT;
          end else begin
            state_reg <= S_WAIT;
          end
        end
        S_STAT: begin
          // clearing the command also acknowledges the done interrupt
          wr_reg <= 1'b1;
          a_reg <= `BDSC_D_CMD;
          d_reg <= 8'h00; // RULE20 RULE3
          state_reg <= S_CLR;
        end
        S_CLR: begin
          wr_reg <= 1'b1;
          a_reg <= `BDSC_D_RC2;
          d_reg <= 8'h00; // RULE19
          state_reg <= S_REST;
        end
        S_REST: begin
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // own register file
  // ----------------------------------------
  wire finish = (state_reg == S_REST);

  always @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= 6'h00;
      haddr_reg <= 24'h000000;
      raddr_reg <= 32'h00000000;
      len_reg <= 24'h000000;
      amod_reg <= 8'h00;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      estat_reg <= 8'h00;
      dcmd_reg <= 8'h00;
    end else begin
      // parameters are frozen while a transfer runs
      if (sw_wr && state_reg == S_IDLE) begin
        if (sw_addr == `BDSC_R_CTRL) begin
          ctrl_reg <= sw_wdata[6:1];
        end else if (sw_addr == `BDSC_R_HADDR) begin
          haddr_reg <= sw_wdata[23:0];
        end else if (sw_addr == `BDSC_R_RADDR) begin
          raddr_reg <= sw_wdata;
        end else if (sw_addr == `BDSC_R_LEN) begin
          len_reg <= sw_wdata[23:0];
        end else if (sw_addr == `BDSC_R_AMOD) begin
          amod_reg <= sw_wdata[7:0];
        end
      end
      if (state_reg == S_CHK) begin
        dcmd_reg <= cap_reg;
      end
      if (state_reg == S_STAT) begin
        estat_reg <= cap_reg & `BDSC_ERR_MASK;
        err_reg <= |(cap_reg & `BDSC_ERR_MASK); // RULE18
      end
      // completion wins over a clear in the same cycle
      if (finish) begin
        done_reg <= 1'b1; // RULE4
      end else if (sw_clr_done || go) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // software read path
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 32'h00000000;
    end else if (sw_rd) begin
      if (sw_addr == `BDSC_R_CTRL) begin
        rdata_reg <= {25'h0000000, ctrl_reg, 1'b0};
      end else if (sw_addr == `BDSC_R_HADDR) begin
        rdata_reg <= {8'h00, haddr_reg};
      end else if (sw_addr == `BDSC_R_RADDR) begin
        rdata_reg <= raddr_reg;
      end else if (sw_addr == `BDSC_R_LEN) begin
        rdata_reg <= {8'h00, len_reg};
      end else if (sw_addr == `BDSC_R_AMOD) begin
        rdata_reg <= {24'h000000, amod_reg};
      end else if (sw_addr == `BDSC_R_STAT) begin
        rdata_reg <= {16'h0000, estat_reg, 5'h00, err_reg, done_reg,
                      (state_reg != S_IDLE)};
      end else if (sw_addr == `BDSC_R_DCMD) begin
        rdata_reg <= {24'h000000, dcmd_reg};
      end else begin
        rdata_reg <= 32'h00000000;
      end
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign sw_rdata = rdata_reg;
  assign dev_addr = a_reg;
  assign dev_wdata = d_reg;
  assign dev_wr = wr_reg;
  assign dev_rd = rd_reg;
  assign busy = (state_reg != S_IDLE);
  assign done = done_reg;
endmodule
`default_nettype wire

// ===== bench/bdsc_chk.sv
// port checker for bdsc_host.
// assumes the register map header and one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "bdsc_map.vh"
module bdsc_chk (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic [3:0] sw_addr, // index
  input wire logic [31:0] sw_wdata, // data
  input wire logic sw_wr, // write
  input wire logic sw_rd, // read
  input wire logic [31:0] sw_rdata, // read data
  input wire logic [7:0] dev_addr, // offset
  input wire logic [7:0] dev_wdata, // data
  input wire logic dev_wr, // write
  input wire logic dev_rd, // read
  input wire logic [7:0] dev_rdata, // read data
  input wire logic dev_irq, // irq
  input wire logic busy, // busy
  input wire logic done // done
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rd_d;
  logic run;
  logic [7:0] last;
  wire cmd_wr = dev_wr && dev_addr == `BDSC_D_CMD;
  // ----
  // helper: last command read-back and transfer window
  // ----
  always @(posedge clk) begin
    if (srst) begin
      rd_d <= 1'h0;
      run <= 1'h0;
      last <= 8'h00;
    end else begin
      rd_d <= dev_rd && dev_addr == `BDSC_D_CMD;
      if (rd_d)
        last <= dev_rdata;
      if (cmd_wr && dev_wdata[7])
        run <= 1'h1;
      else if (rd_d && dev_rdata[1])
        run <= 1'h0;
    end
  end
  sequence close_s;
    cmd_wr && dev_wdata == 8'h00 ##1 dev_wr && dev_addr == `BDSC_D_RC2 && dev_wdata == 8'h00;
  endsequence
  go_starts_a: assert property (
    sw_wr && sw_addr == `BDSC_R_CTRL && sw_wdata[0] && !busy |-> ##[1:3] cmd_wr && !dev_wdata[7])
    else $error("go gave no setup write");
  setup_clear_a: assert property (
    cmd_wr && !dev_wdata[7] |-> dev_wdata[3] == 1'h0 && dev_wdata[1:0] == 2'h0)
    else $error("setup command has status bits");
  start_rb_a: assert property (cmd_wr && dev_wdata[7] |-> dev_wdata == (last | 8'h80))
    else $error("start is not read-back with start");
  rc2_set_a: assert property (
    dev_wr && dev_addr == `BDSC_D_RC2 && dev_wdata != 8'h00 |->
    dev_wdata[4] && !dev_wdata[6] && (!dev_wdata[7] || dev_wdata[5]))
    else $error("bad remote control value");
  rem_pair_a: assert property (dev_wr && dev_addr == `BDSC_D_RREM |->
    $past(dev_wr) && $past(dev_addr) == `BDSC_D_LREM && dev_wdata == $past(dev_wdata))
    else $error("remainders differ");
  quiet_run_a: assert property (run |-> !dev_wr && (!dev_rd || dev_addr == `BDSC_D_CMD))
    else $error("cable access during transfer");
  close_done_a: assert property (close_s |-> ##[1:2] done && !busy)
    else $error("no completion after close");
  stat_rd_a: assert property (sw_rd && sw_addr == `BDSC_R_STAT |=>
    sw_rdata[1:0] == {$past(done), $past(busy)})
    else $error("status flags wrong");
endmodule
bind bdsc_host bdsc_chk u_chk (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
  .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
  .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
  .dev_irq(dev_irq), .busy(busy), .done(done));
`default_nettype wire

// ===== bench/bdsc_dev.sv
// behavioural adapter register file with a timed transfer.
// assumes one write per strobe and read data the cycle after.
`timescale 1ns/100ps
`default_nettype none
module bdsc_dev (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic [7:0] dev_addr, // offset
  input wire logic [7:0] dev_wdata, // data
  input wire logic dev_wr, // write
  input wire logic dev_rd, // read
  input wire logic [7:0] err_stat, // status at finish
  output logic [7:0] dev_rdata, // read data
  output logic dev_irq // irq
);
  logic [7:0] mem [0:15];
  logic [9:0] cnt;
  logic act;
  logic [23:0] hptr;
  logic [15:0] map_last;
  logic [15:0] map_off;
  logic [8:0] ten;
  logic [8:0] ten_max;
  logic stall;
  // ----
  // registers and transfer timer
  // ----
  assign act = mem[0][1] & mem[0][2] & mem[12][6];
  assign dev_irq = act;
  // entry of the page under hptr, one longword per entry
  assign map_off = 16'hC000 + {2'h0, hptr[23:12], 2'h0};
  // bytes per bus tenure: 64 in pause, 256 in block, one otherwise
  assign ten_max = mem[13][5] ? (mem[13][7] ? 9'h040 : 9'h100) : 9'h001;
  // a new page costs an entry fetch, a full tenure a rearbitration
  assign stall = (map_off != map_last) || (ten == ten_max);
  always @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++)
        mem[i] <= 8'h00;
      cnt <= 10'h000;
      dev_rdata <= 8'h00;
      hptr <= 24'h000000;
      map_last <= 16'h0000;
      ten <= 9'h000;
    end else begin
      // a released bus toggles so stale data never looks valid
      dev_rdata <= ~dev_rdata;
      if (dev_rd)
        dev_rdata <= dev_addr[3:0] == 4'hC ? {act, mem[12][6:0]} : mem[dev_addr[3:0]];
      if (dev_wr) begin
        mem[dev_addr[3:0]] <= dev_wdata;
        if (dev_addr == 8'h00 && dev_wdata[7]) begin
          mem[0][0] <= 1'h1;
          cnt <= {2'h0, mem[8]} + {2'h0, mem[10]} + 10'h008;
          hptr <= {mem[3], mem[2], mem[1]};
          ten <= 9'h000;
        end
      end else if (mem[0][0]) begin
        map_last <= map_off;
        if (stall)
          ten <= 9'h000;
        else if (cnt == 10'h000) begin
          mem[0][1:0] <= 2'h2;
          mem[15] <= err_stat;
        end else begin
          cnt <= cnt - 10'h001;
          hptr <= hptr + 24'h000001;
          ten <= ten + 9'h001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_bdsc_host.sv
// self-checking bench for bdsc_host against the adapter model.
// assumes bdsc_dev, bdsc_chk and the register map header.
`timescale 1ns/100ps
`default_nettype none
`include "bdsc_map.vh"
module tb_bdsc_host;
  typedef struct packed {
    logic [5:0] opt;
    logic [23:0] ha;
    logic [31:0] ra;
    logic [23:0] len;
    logic [7:0] am;
    logic [7:0] err;
  } bdsc_row_t;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic [7:0] err_stat = 8'h00;
  wire [31:0] sw_rdata;
  wire [7:0] dev_addr, dev_wdata, dev_rdata;
  wire dev_wr, dev_rd, dev_irq, busy, done;
  int miscompares = 0;
  int compares = 0;
  int run = 0;
  int irun = 0;
  int wrun [0:15];
  logic [7:0] first [0:15];
  logic [31:0] d;
  bdsc_row_t rows [0:3];
  bdsc_row_t r;
  always #50 clk = ~clk;
  bdsc_host dut (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_irq(dev_irq), .busy(busy),
    .done(done));
  bdsc_dev dev (.clk(clk), .srst(srst), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .err_stat(err_stat), .dev_rdata(dev_rdata),
    .dev_irq(dev_irq));
  // ----
  // first device write per offset in each run, irq seen per run
  // ----
  always @(posedge clk) begin
    if (dev_wr && wrun[dev_addr[3:0]] != run) begin
      wrun[dev_addr[3:0]] <= run;
      first[dev_addr[3:0]] <= dev_wdata;
    end
    if (dev_irq)
      irun <= run;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic sw_w(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'h1;
    @(posedge clk);
    sw_wr <= 1'h0;
  endtask
  task automatic sw_r(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk);
    sw_rd <= 1'h0;
    @(negedge clk);
    v = sw_rdata;
  endtask
  task automatic start(input bdsc_row_t x);
    run++;
    sw_w(`BDSC_R_HADDR, {8'h00, x.ha});
    err_stat <= x.err;
    sw_w(`BDSC_R_RADDR, x.ra);
    sw_w(`BDSC_R_LEN, {8'h00, x.len});
    sw_w(`BDSC_R_AMOD, {24'h0, x.am});
    sw_w(`BDSC_R_CTRL, {25'h0, x.opt, 1'h1});
  endtask
  task automatic wait_done();
    for (int i = 0; i < 4000 && done !== 1'h1; i++)
      @(posedge clk);
    @(negedge clk);
    chk("done", done, 32'h1);
  endtask
  function automatic logic [7:0] expb(input bdsc_row_t x, input int a);
    case (a)
      0: return {1'h0, x.opt[2], x.opt[0], x.opt[1], 1'h0, x.opt[3], 2'h0};
      1, 2, 3: return x.ha[8*(a-1) +: 8];
      4, 5, 6, 7: return x.ra[8*(a-4) +: 8];
      8, 9: return x.len[7:0];
      10: return x.len[15:8];
      11: return x.len[23:16];
      12: return {1'h0, x.opt[3], 6'h00};
      13: return {x.opt[5], 1'h0, x.opt[4] | x.opt[5], 5'h10};
      default: return x.am;
    endcase
  endfunction
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs about 2000 cycles
  initial begin
    #3000000;
    miscompares++;
    end_of_test();
  end
  initial begin
    rows[0] = {6'h13, 24'h000000, 32'h12340000, 24'h000140, 8'h0F, 8'h00};
    rows[1] = {6'h2C, 24'hABC123, 32'h00FF0001, 24'hA55A3C, 8'h09, 8'h38};
    rows[2] = {6'h08, 24'hFFFFFF, 32'hFFFFFFFF, 24'h000000, 8'h0B, 8'hC7};
    rows[3] = {6'h00, 24'h001FFF, 32'h00000100, 24'h0000FF, 8'h3D, 8'h01};
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    for (int a = 0; a < 8; a++) begin
      sw_r(a[3:0], d);
      chk("reset reg", d, 32'h0);
    end
    chk("reset flags", {busy, done}, 32'h0);
    $display("reset values done");
    foreach (rows[i]) begin
      r = rows[i];
      start(r);
      wait_done();
      for (int a = 0; a < 15; a++)
        chk("dev byte", first[a], expb(r, a));
      sw_r(`BDSC_R_STAT, d);
      chk("status", d, {16'h0, r.err & 8'hC7, 5'h00, |(r.err & 8'hC7), 2'h2});
      chk("irq seen", irun == run, r.opt[3]);
      chk("irq off", dev_irq, 32'h0);
      sw_w(`BDSC_R_STAT, 32'h2);
      @(negedge clk);
      chk("done clr", done, 32'h0);
      $display("row %0d done", i);
    end
    r = rows[3];
    start(r);
    sw_w(`BDSC_R_LEN, 32'h123456);
    sw_w(`BDSC_R_CTRL, 32'h1);
    wait_done();
    sw_r(`BDSC_R_LEN, d);
    chk("len kept", d, {8'h0, r.len});
    sw_r(`BDSC_R_DCMD, d);
    chk("last cmd", d, {24'h0, expb(r, 0) | 8'h82});
    $display("busy refusal done");
    start(rows[0]);
    @(negedge clk);
    chk("go clears done", done, 32'h0);
    repeat (30) @(posedge clk);
    srst <= 1'h1;
    @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    chk("mid reset", {busy, done}, 32'h0);
    $display("mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
